// *** ivq_params.svh ***
// Constants for the interrupt vector queue logic.
// Assumes inclusion by the package and the design modules only.
`ifndef IVQ_PARAMS_SVH
`define IVQ_PARAMS_SVH
`define IVQ_VEC_W 32
`define IVQ_FIFO_DEPTH 16
`define IVQ_NUM_QUEUES 10
`define IVQ_QIDX_W 4
`define IVQ_SRC_MSB 31
`define IVQ_DMA_SRC_MSB 30
`define IVQ_SRC_LSB 28
`define IVQ_CFG_SRC 4'ha
`define IVQ_CFG_QUEUE 4'h8
`define IVQ_PERIPH_QUEUE 4'h9
`define IVQ_HI_BIT 18
`define IVQ_FI_BIT 17
`define IVQ_ERR_BIT 16
`define IVQ_ARF_BIT 1
`define IVQ_ACK_BIT 0
`endif

// *** ivq_pkg.sv ***
// Types shared by the interrupt vector queue modules.
// Assumes ivq_params.svh is reachable by bare name.
`include "ivq_params.svh"
package ivq_pkg;
    typedef logic [`IVQ_VEC_W-1:0] ivq_vec_t;
    typedef logic [`IVQ_QIDX_W-1:0] ivq_qidx_t;
    typedef enum logic [1:0] {
        IVQ_IDLE = 2'b00,
        IVQ_WRITE = 2'b01,
        IVQ_WAIT = 2'b10
    } ivq_state_t;
endpackage : ivq_pkg

// *** ivq_fifo_if.sv ***
// Interface between the central vector FIFO and the queue mover.
// Assumes a single clock shared by both ends.
`timescale 1ns/1ps
interface ivq_fifo_if;
    import ivq_pkg::*;
    ivq_vec_t data;
    logic valid;
    logic ready;
    modport source (output data, output valid, input ready);
    modport sink (input data, input valid, output ready);
endinterface : ivq_fifo_if

// *** ivq_fifo.sv ***
// Central interrupt vector FIFO built from flip-flops.
// Assumes writer holds data while push_ready is low.
`timescale 1ns/1ps
`include "ivq_params.svh"
module ivq_fifo
    import ivq_pkg::*;
#(
    parameter int DEPTH = `IVQ_FIFO_DEPTH
)
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire ivq_vec_t push_data,
    input wire logic push_valid,
    output logic push_ready,
    ivq_fifo_if.source out
);
    localparam int AW = $clog2(DEPTH);
    ivq_vec_t mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic do_push;
    logic do_pop;
    logic has_room;

    // Ready drops one entry early, so a registered copy upstream never overfills
    assign has_room = (count != DEPTH[AW:0]);
    assign push_ready = (count < (AW+1)'(DEPTH - 1));
    assign out.valid = (count != '0);
    assign out.data = mem[rd_ptr];
    assign do_push = push_valid && has_room;
    assign do_pop = out.valid && out.ready;

    always_ff @(posedge clk_sys)
    begin
        if (do_push)
        begin
            mem[wr_ptr] <= push_data;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end
        else
        begin
            if (do_push)
            begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (do_pop)
            begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(do_push) - (AW+1)'(do_pop);
        end
    end
endmodule : ivq_fifo

// *** ivq_top.sv ***
// Interrupt vector builder, central FIFO and queue mover.
// Assumes the host memory writer answers each write with a done pulse.
// Contract
// - Vectors wait in one central sixteen-entry 32-bit FIFO.
// - Each vector is written to one of ten queues chosen by its source.
// - New vectors set per-queue status bits; host clears each by writing one.
// - Interrupt line asserted while any queue status bit is pending.
// - Upper four bits of each vector identify the source type.
// - Configuration vector holds source 1010, zeros, two flags; goes to config queue.
// - Bit 1 set when the last action request failed.
// - Bit 0 set when the last action request succeeded.
// - DMA vector bit 31 clear, three-bit channel/direction source, matching queue.
// - DMA vector bits besides source and three flags are zero.
// - Host-initiated flag set when descriptor interrupt mark was found.
// - Receive frame flag set on frame branch or hold at finish.
// - Transmit error flag on hold without frame end, or zero count without.
// - Receive error flag when frame could not be fully stored.
`timescale 1ns/1ps
`include "ivq_params.svh"
module ivq_top
    import ivq_pkg::*;
#(
    parameter int DEPTH = `IVQ_FIFO_DEPTH,
    parameter int NQ = `IVQ_NUM_QUEUES
)
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic cfg_done,
    input wire logic request_failed_flag,
    input wire logic dma_event,
    input wire logic dma_tx,
    input wire logic [1:0] dma_channel,
    input wire logic host_initiated_flag,
    input wire logic frame_branch,
    input wire logic finish_hold,
    input wire logic frame_end_mark,
    input wire logic zero_byte_count,
    input wire logic rx_incomplete,
    input wire logic periph_valid,
    input wire ivq_vec_t periph_vector,
    input wire logic [NQ-1:0] status_ack,
    input wire logic mem_done,
    output logic event_ready,
    output logic mem_write,
    output ivq_qidx_t mem_queue,
    output ivq_vec_t mem_data,
    output logic [NQ-1:0] global_queue_status,
    output logic int_active
);
    ivq_fifo_if fifo_out ();
    ivq_vec_t next_push;
    logic push_valid;
    logic push_ready;
    ivq_vec_t config_vector;
    ivq_vec_t dma_vector;
    ivq_state_t state;
    logic [NQ-1:0] next_status;
    logic [NQ-1:0] set_mask;

    // Source code in bits 31..28 selects the destination queue
    function automatic ivq_qidx_t queue_of(input ivq_vec_t v);
        if (v[`IVQ_SRC_MSB] == 1'b0)
            return {1'b0, v[`IVQ_DMA_SRC_MSB:`IVQ_SRC_LSB]};
        else if (v[`IVQ_SRC_MSB:`IVQ_SRC_LSB] == `IVQ_CFG_SRC)
            return `IVQ_CFG_QUEUE;
        else
            return `IVQ_PERIPH_QUEUE;
    endfunction : queue_of

    // Configuration vector: all zero except the source and two flags
    always_comb
    begin
        config_vector = '0;
        config_vector[`IVQ_SRC_MSB:`IVQ_SRC_LSB] = `IVQ_CFG_SRC;
        config_vector[`IVQ_ARF_BIT] = request_failed_flag;
        config_vector[`IVQ_ACK_BIT] = !request_failed_flag;
    end

    always_comb
    begin
        dma_vector = '0;
        dma_vector[`IVQ_DMA_SRC_MSB:`IVQ_SRC_LSB] = {dma_tx, dma_channel};
        dma_vector[`IVQ_HI_BIT] = host_initiated_flag;
        if (dma_tx)
        begin
            dma_vector[`IVQ_FI_BIT] = frame_branch || (finish_hold && frame_end_mark);
            dma_vector[`IVQ_ERR_BIT] = !frame_end_mark
                && (finish_hold || zero_byte_count);
        end
        else
        begin
            dma_vector[`IVQ_FI_BIT] = frame_branch || finish_hold;
            dma_vector[`IVQ_ERR_BIT] = rx_incomplete;
        end
    end

    // Priority: configuration, then DMA, then peripheral; losers wait
    always_comb
    begin
        push_valid = cfg_done || dma_event || periph_valid;
        if (cfg_done)
            next_push = config_vector;
        else if (dma_event)
            next_push = dma_vector;
        else
            next_push = periph_vector;
    end

    // Sources see back-pressure through event_ready; the FIFO lowers
    // push_ready a cycle early so this registered copy never drops a push
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            event_ready <= 1'b0;
        else
            event_ready <= push_ready;
    end

    ivq_fifo #(.DEPTH(DEPTH)) u_fifo (
        .clk_sys(clk_sys),
        .reset(reset),
        .push_data(next_push),
        .push_valid(push_valid && event_ready),
        .push_ready(push_ready),
        .out(fifo_out.source)
    );

    assign fifo_out.ready = (state == IVQ_IDLE);

    // One vector in flight to host memory at a time
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            state <= IVQ_IDLE;
            mem_write <= 1'b0;
            mem_queue <= '0;
            mem_data <= '0;
        end
        else
        begin
            mem_write <= 1'b0;
            unique case (state)
                IVQ_IDLE:
                begin
                    if (fifo_out.valid)
                    begin
                        mem_data <= fifo_out.data;
                        mem_queue <= queue_of(fifo_out.data);
                        mem_write <= 1'b1;
                        state <= IVQ_WAIT;
                    end
                end
                IVQ_WRITE:
                begin
                    state <= IVQ_WAIT;
                end
                IVQ_WAIT:
                begin
                    if (mem_done)
                        state <= IVQ_IDLE;
                end
                default:
                begin
                    state <= IVQ_IDLE;
                end
            endcase
        end
    end

    // Set wins over a clear arriving in the same cycle
    always_comb
    begin
        set_mask = '0;
        if (state == IVQ_WAIT && mem_done)
            set_mask[mem_queue] = 1'b1;
        next_status = (global_queue_status & ~status_ack) | set_mask;
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            global_queue_status <= '0;
            int_active <= 1'b0;
        end
        else
        begin
            global_queue_status <= next_status;
            int_active <= |next_status;
        end
    end
endmodule : ivq_top

// *** ivq_top_assertions.sv ***
// Concurrent checks on the queue writes, status bits and interrupt level.
// Assumes it is bound to ivq_top and sees only its ports.
`timescale 1ns/1ps
module ivq_top_assertions
    import ivq_pkg::*;
#(
    parameter int NQ = 10
)
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic mem_done,
    input wire logic [NQ-1:0] status_ack,
    input wire logic mem_write,
    input wire ivq_qidx_t mem_queue,
    input wire ivq_vec_t mem_data,
    input wire logic [NQ-1:0] global_queue_status,
    input wire logic int_active
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    AST_CFG_FORMAT: assert property (mem_write && mem_queue == 4'h8 |->
        mem_data[31:2] == 30'h28000000)
        else $error("bad config vector");
    AST_CFG_FLAGS: assert property (mem_write && mem_queue == 4'h8 |-> ^mem_data[1:0])
        else $error("bad config flags");
    AST_DMA_FORMAT: assert property (mem_write && mem_queue < 4'h8 |->
        {mem_data[31], mem_data[27:19], mem_data[15:0]} == 26'h0)
        else $error("bad dma vector");
    AST_DMA_SOURCE: assert property (mem_write && mem_queue < 4'h8 |->
        mem_data[31:28] == mem_queue)
        else $error("dma source and queue differ");
    AST_STATUS_SET: assert property (mem_done |=> global_queue_status[$past(mem_queue)])
        else $error("status bit not set");
    // A bit may only appear after a finished write, never by itself
    AST_STATUS_CAUSE: assert property (
        (global_queue_status & ~$past(global_queue_status)) != 0 |-> $past(mem_done))
        else $error("status bit without write");
    AST_ACK_CLEAR: assert property (status_ack != 0 && !mem_done
        |=> (global_queue_status & $past(status_ack)) == 0)
        else $error("ack did not clear");
    AST_INT_LEVEL: assert property (int_active == (|global_queue_status))
        else $error("interrupt level wrong");
endmodule : ivq_top_assertions
bind ivq_top ivq_top_assertions #(.NQ(NQ)) ivq_top_assertions_i (
    .clk_sys(clk_sys),
    .reset(reset),
    .mem_done(mem_done),
    .status_ack(status_ack),
    .mem_write(mem_write),
    .mem_queue(mem_queue),
    .mem_data(mem_data),
    .global_queue_status(global_queue_status),
    .int_active(int_active)
);

// *** ivq_host_model.sv ***
// Host memory writer model: answers each queue write with a done pulse.
// Assumes a shared clock; stall holds the answer back so the FIFO fills.
`timescale 1ns/1ps
module ivq_host_model
(
    input wire logic clk_sys,
    input wire logic mem_write,
    input wire logic stall,
    output logic mem_done = 1'b0
);
    int cnt = -1;
    // Random 0-3 cycle latency covers a prompt and a slow host
    always @(posedge clk_sys)
    begin
        mem_done <= cnt == 0 && !stall;
        if (mem_write)
            cnt <= $urandom_range(3);
        else if (cnt >= 0 && !stall)
            cnt <= cnt - 1;
    end
endmodule : ivq_host_model

// *** interrupt_vector_queue_logic_test.sv ***
// Self-checking bench: directed and random vectors, acks, FIFO fill.
// Assumes the host model answers writes; one directed peripheral vector.
`timescale 1ns/1ps
module interrupt_vector_queue_logic_test;
    import ivq_pkg::*;
    logic clk_sys = 1'b0, reset = 1'b1, cfg_done = 1'b0, request_failed_flag = 1'b0;
    logic dma_event = 1'b0, dma_tx = 1'b0, host_initiated_flag = 1'b0, frame_branch = 1'b0;
    logic finish_hold = 1'b0, frame_end_mark = 1'b0, zero_byte_count = 1'b0;
    logic rx_incomplete = 1'b0, periph_valid = 1'b0, stall = 1'b0, auto_ack = 1'b0;
    logic [1:0] dma_channel = 2'h0;
    ivq_vec_t periph_vector = 32'h0;
    logic [9:0] status_ack = 10'h0;
    logic mem_done, event_ready, mem_write, int_active;
    ivq_qidx_t mem_queue;
    ivq_vec_t mem_data;
    logic [9:0] global_queue_status;
    logic [35:0] exp_q[$];
    int failures = 0;
    int tests_run = 0;
    int n = 0;
    ivq_top ivq_top_i (
        .clk_sys(clk_sys),
        .reset(reset),
        .cfg_done(cfg_done),
        .request_failed_flag(request_failed_flag),
        .dma_event(dma_event),
        .dma_tx(dma_tx),
        .dma_channel(dma_channel),
        .host_initiated_flag(host_initiated_flag),
        .frame_branch(frame_branch),
        .finish_hold(finish_hold),
        .frame_end_mark(frame_end_mark),
        .zero_byte_count(zero_byte_count),
        .rx_incomplete(rx_incomplete),
        .periph_valid(periph_valid),
        .periph_vector(periph_vector),
        .status_ack(status_ack),
        .mem_done(mem_done),
        .event_ready(event_ready),
        .mem_write(mem_write),
        .mem_queue(mem_queue),
        .mem_data(mem_data),
        .global_queue_status(global_queue_status),
        .int_active(int_active)
    );
    ivq_host_model ivq_host_model_i (
        .clk_sys(clk_sys),
        .mem_write(mem_write),
        .stall(stall),
        .mem_done(mem_done)
    );
    always #20 clk_sys = ~clk_sys;
    // f = {tx, channel, host, branch, hold, frame end, zero count, incomplete}
    function automatic logic [35:0] dma_exp(logic [8:0] f);
        return {1'b0, f[8:6], 1'b0, f[8:6], 9'h0, f[5],
            f[8] ? f[4] | f[3] & f[2] : f[4] | f[3],
            f[8] ? (f[3] | f[1]) & !f[2] : f[0], 16'h0};
    endfunction : dma_exp
    task automatic check(logic [35:0] got, logic [35:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    // Both requests may be raised together; the lower one must wait its turn
    task automatic send(logic c, logic d, logic fl, logic [8:0] f);
        @(posedge clk_sys);
        {dma_tx, dma_channel, host_initiated_flag, frame_branch, finish_hold,
            frame_end_mark, zero_byte_count, rx_incomplete} <= f;
        request_failed_flag <= fl;
        cfg_done <= c;
        dma_event <= d;
        while (c || d)
        begin
            @(posedge clk_sys);
            if (event_ready && c)
            begin
                c = 1'b0;
                cfg_done <= 1'b0;
                exp_q.push_back({8'h8a, 26'h0, fl, !fl});
            end
            else if (event_ready)
            begin
                d = 1'b0;
                dma_event <= 1'b0;
                exp_q.push_back(dma_exp(f));
            end
        end
    endtask : send
    task automatic drain;
        while (exp_q.size() != 0)
            @(posedge clk_sys);
        repeat (8) @(posedge clk_sys);
    endtask : drain
    task automatic ack(logic [9:0] m);
        status_ack <= m;
        @(posedge clk_sys);
        status_ack <= 10'h0;
        repeat (2) @(posedge clk_sys);
    endtask : ack
    task automatic wrap_up;
        $display("checks %0d, failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : wrap_up
    always @(posedge clk_sys)
        if (mem_write)
            check({mem_queue, mem_data}, exp_q.size() ? exp_q.pop_front() : 36'hx);
    always @(posedge clk_sys)
        if (auto_ack)
            status_ack <= 10'($urandom);
    initial
    begin
        #800000;
        failures++;
        wrap_up();
    end
    initial
    begin
        void'($urandom(32'h8218));
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        repeat (2) @(posedge clk_sys);
        send(1'b1, 1'b1, 1'b0, 9'h040);
        drain();
        check({26'h0, global_queue_status}, 36'h102);
        ack(10'h100);
        check({25'h0, int_active, global_queue_status}, 36'h402);
        ack(10'h002);
        check({25'h0, int_active, global_queue_status}, 36'h0);
        // Prebuilt vector with a foreign source lands in the peripheral queue
        periph_vector <= {4'hc, 28'($urandom)};
        periph_valid <= 1'b1;
        @(posedge clk_sys);
        while (!event_ready)
            @(posedge clk_sys);
        periph_valid <= 1'b0;
        exp_q.push_back({4'h9, periph_vector});
        drain();
        check({26'h0, global_queue_status}, 36'h200);
        ack(10'h200);
        send(1'b1, 1'b0, 1'b1, 9'h0);
        for (int i = 0; i < 8; i++)
            send(1'b0, 1'b1, 1'b0, {i[2:0], 6'($urandom)});
        auto_ack <= 1'b1;
        repeat (300)
            send(1'($urandom), 1'b1, 1'($urandom), 9'($urandom));
        drain();
        // Host stalls so only the FIFO and the mover can absorb vectors
        stall <= 1'b1;
        request_failed_flag <= 1'b1;
        cfg_done <= 1'b1;
        repeat (40)
        begin
            @(posedge clk_sys);
            if (event_ready)
            begin
                n++;
                exp_q.push_back({8'h8a, 26'h0, 2'b10});
            end
        end
        cfg_done <= 1'b0;
        // Sixteen held in the FIFO plus one parked in the mover
        check(36'(n == 17 && !event_ready), 36'h1);
        stall <= 1'b0;
        drain();
        wrap_up();
    end
endmodule : interrupt_vector_queue_logic_test
